// ==== verilog/dscg_defines.svh ====
`ifndef DSCG_DEFINES_SVH
`define DSCG_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DSCG_SYS_BASE 32'h400F_E000
`define DSCG_RUN_CFG_OFF 12'h060
`define DSCG_RUN_GATE_OFF 12'h100
`define DSCG_SLEEP_GATE_OFF 12'h110
`define DSCG_DEEP_GATE_OFF 12'h120
`define DSCG_STATUS_OFF 12'h130
`define DSCG_MASK_OFF 12'h134

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DSCG_BIT_PWM 20
`define DSCG_BIT_ADC0 16
`define DSCG_BIT_HIBERNATION 6
`define DSCG_BIT_WATCHDOG 3
`define DSCG_BIT_AUTO_GATE 27
`define DSCG_GATE_WMASK 32'h0011_0048
`define DSCG_GATE_RST 32'h0000_0040
`define DSCG_CFG_RST 32'h0000_0000
`define DSCG_RESP_OKAY 2'h0
`define DSCG_RESP_SLVERR 2'h2

`endif

// ==== verilog/dscg_pkg.sv ====
`default_nettype none

package dscg_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DSCG_RUN = 2'h0,
    DSCG_SLEEP = 2'h1,
    DSCG_DEEP = 2'h3
  } dscg_mode_t;

  typedef struct packed {
    logic pwm;
    logic adc0;
    logic hibernation;
    logic watchdog;
  } dscg_units_t;

  typedef struct packed {
    dscg_units_t req;
    dscg_units_t en;
  } dscg_sync_state_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] run_clock_config;
    logic [31:0] run_clock_gate_0;
    logic [31:0] sleep_clock_gate_0;
    logic [31:0] deep_sleep_clock_gate_0;
    logic [31:0] status;
    logic [31:0] mask;
    dscg_mode_t mode;
    logic periph_fault;
    logic periph_done;
    logic irq;
  } dscg_state_t;

endpackage

`default_nettype wire

// ==== verilog/dscg_gate_sync.sv ====
`timescale 1ns/100ps
`default_nettype none

module dscg_gate_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dscg_pkg::dscg_units_t req_en,
  output dscg_pkg::dscg_units_t clk_en
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam dscg_pkg::dscg_sync_state_t RST = '{
    req: '{pwm: 1'b0, adc0: 1'b0, hibernation: 1'b1, watchdog: 1'b0},
    en: '{pwm: 1'b0, adc0: 1'b0, hibernation: 1'b1, watchdog: 1'b0}
  };

  dscg_pkg::dscg_sync_state_t q;
  dscg_pkg::dscg_sync_state_t next_q;

  // ----------------------------------------------------------------
  // enable only moves once the request held steady for one edge,
  // so a mode switch and a register write in adjacent cycles cannot
  // produce a one-cycle runt enable
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.req = req_en;
    if (req_en == q.req) begin
      next_q.en = q.req;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= next_q;
    end
  end

  assign clk_en = q.en;

endmodule // dscg_gate_sync

`default_nettype wire

// ==== verilog/dscg_top.sv ====
// Summary of operation
// - each writable gating bit is the clock enable of one unit
// - access to a unit whose clock is gated off answers with a fault
// - deep-sleep gating register resets to 0x00000040, hibernation on
// - run, sleep and deep-sleep copies; deep copy applies in deep-sleep
// - sleep and deep copies used only when auto gating select is set
// - bit 20 gates the pwm unit, read-write, resets to zero
// - bit 16 gates converter unit 0, read-write, resets to zero
// - bit 6 gates the hibernation unit, read-write, resets to one
// - bit 3 gates the watchdog unit, read-write, resets to zero
// - all other bits read-only and read as zero
// - deep-sleep gating register decodes at offset 0x120
`include "dscg_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module dscg_top #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_req,
  input wire logic deep_sleep_req,
  input wire logic periph_req,
  input wire dscg_pkg::dscg_units_t periph_sel,
  output logic periph_fault,
  output logic periph_done,
  output dscg_pkg::dscg_units_t unit_clk_en,
  output logic [1:0] power_mode,
  output logic irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic dscg_pkg::dscg_units_t reg_to_units(
    input logic [31:0] r
  );
    dscg_pkg::dscg_units_t u;
    u.pwm = r[`DSCG_BIT_PWM];
    u.adc0 = r[`DSCG_BIT_ADC0];
    u.hibernation = r[`DSCG_BIT_HIBERNATION];
    u.watchdog = r[`DSCG_BIT_WATCHDOG];
    return u;
  endfunction

  function automatic logic [31:0] units_to_reg(
    input dscg_pkg::dscg_units_t u
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    r[`DSCG_BIT_PWM] = u.pwm;
    r[`DSCG_BIT_ADC0] = u.adc0;
    r[`DSCG_BIT_HIBERNATION] = u.hibernation;
    r[`DSCG_BIT_WATCHDOG] = u.watchdog;
    return r;
  endfunction

  function automatic logic [31:0] strb_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] strb_bits(
    input logic [31:0] wd,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic addr_known(input logic [11:0] a);
    case (a)
      `DSCG_RUN_CFG_OFF,
      `DSCG_RUN_GATE_OFF,
      `DSCG_SLEEP_GATE_OFF,
      `DSCG_DEEP_GATE_OFF,
      `DSCG_STATUS_OFF,
      `DSCG_MASK_OFF: addr_known = 1'b1;
      default: addr_known = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam logic [31:0] CFG_WMASK = 32'h0000_0001 << `DSCG_BIT_AUTO_GATE;

  localparam dscg_pkg::dscg_state_t RST = '{
    awready: 1'b0,
    wready: 1'b0,
    bvalid: 1'b0,
    bresp: `DSCG_RESP_OKAY,
    arready: 1'b0,
    rvalid: 1'b0,
    rresp: `DSCG_RESP_OKAY,
    rdata: 32'h0000_0000,
    aw_got: 1'b0,
    w_got: 1'b0,
    awaddr: 12'h000,
    wdata: 32'h0000_0000,
    wstrb: 4'h0,
    run_clock_config: `DSCG_CFG_RST,
    run_clock_gate_0: `DSCG_GATE_RST,
    sleep_clock_gate_0: `DSCG_GATE_RST,
    deep_sleep_clock_gate_0: `DSCG_GATE_RST,
    status: 32'h0000_0000,
    mask: 32'h0000_0000,
    mode: dscg_pkg::DSCG_RUN,
    periph_fault: 1'b0,
    periph_done: 1'b0,
    irq: 1'b0
  };

  dscg_pkg::dscg_state_t q;
  dscg_pkg::dscg_state_t next_q;
  dscg_pkg::dscg_units_t sel_en;
  dscg_pkg::dscg_units_t gate_en;
  logic [11:0] araddr;
  logic [11:0] wr_addr;
  logic auto_gate;

  assign araddr = 12'(s_axi_araddr);
  assign auto_gate = q.run_clock_config[`DSCG_BIT_AUTO_GATE];

  // ----------------------------------------------------------------
  // gate selection by power mode
  // ----------------------------------------------------------------
  always_comb begin
    sel_en = reg_to_units(q.run_clock_gate_0);
    if (auto_gate) begin
      case (q.mode)
        dscg_pkg::DSCG_SLEEP: begin
          sel_en = reg_to_units(q.sleep_clock_gate_0);
        end
        dscg_pkg::DSCG_DEEP: begin
          sel_en = reg_to_units(q.deep_sleep_clock_gate_0);
        end
        default: begin
          sel_en = reg_to_units(q.run_clock_gate_0);
        end
      endcase
    end
  end

  // registered enables feed both the units and the fault check
  dscg_gate_sync dscg_gate_sync_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .req_en(sel_en),
    .clk_en(gate_en)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wbits;
    logic [31:0] fault_set;
    logic do_write;
    wbits = 32'h0000_0000;
    fault_set = 32'h0000_0000;
    do_write = 1'b0;
    wr_addr = q.awaddr;
    next_q = q;

    // power mode, held in step with the core's requests
    case (q.mode)
      dscg_pkg::DSCG_RUN: begin
        if (sleep_req) begin
          next_q.mode = dscg_pkg::DSCG_SLEEP;
        end
      end
      dscg_pkg::DSCG_SLEEP: begin
        if (!sleep_req) begin
          next_q.mode = dscg_pkg::DSCG_RUN;
        end else if (deep_sleep_req) begin
          next_q.mode = dscg_pkg::DSCG_DEEP;
        end
      end
      dscg_pkg::DSCG_DEEP: begin
        if (!sleep_req || !deep_sleep_req) begin
          next_q.mode = dscg_pkg::DSCG_SLEEP;
        end
      end
      default: begin
        next_q.mode = dscg_pkg::DSCG_RUN;
      end
    endcase

    // unit access check against the enables in force
    next_q.periph_fault = 1'b0;
    next_q.periph_done = 1'b0;
    if (periph_req) begin
      if ((periph_sel & ~gate_en) != 4'h0) begin
        next_q.periph_fault = 1'b1;
        fault_set = units_to_reg(periph_sel & ~gate_en);
      end else begin
        next_q.periph_done = 1'b1;
      end
    end

    // write address and data, taken in either order
    if (s_axi_awvalid && q.awready) begin
      next_q.aw_got = 1'b1;
      next_q.awaddr = 12'(s_axi_awaddr);
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.w_got = 1'b1;
      next_q.wdata = s_axi_wdata;
      next_q.wstrb = s_axi_wstrb;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      do_write = addr_known(wr_addr);
      wbits = strb_bits(q.wdata, q.wstrb);
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = do_write ? `DSCG_RESP_OKAY : `DSCG_RESP_SLVERR;
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    if (do_write) begin
      case (wr_addr)
        `DSCG_RUN_CFG_OFF: begin
          next_q.run_clock_config =
            strb_merge(q.run_clock_config, q.wdata, q.wstrb) & CFG_WMASK;
        end
        `DSCG_RUN_GATE_OFF: begin
          next_q.run_clock_gate_0 =
            strb_merge(q.run_clock_gate_0, q.wdata, q.wstrb)
            & `DSCG_GATE_WMASK;
        end
        `DSCG_SLEEP_GATE_OFF: begin
          next_q.sleep_clock_gate_0 =
            strb_merge(q.sleep_clock_gate_0, q.wdata, q.wstrb)
            & `DSCG_GATE_WMASK;
        end
        `DSCG_DEEP_GATE_OFF: begin
          next_q.deep_sleep_clock_gate_0 =
            strb_merge(q.deep_sleep_clock_gate_0, q.wdata, q.wstrb)
            & `DSCG_GATE_WMASK;
        end
        `DSCG_MASK_OFF: begin
          next_q.mask =
            strb_merge(q.mask, q.wdata, q.wstrb) & `DSCG_GATE_WMASK;
        end
        default: begin
          next_q.mask = q.mask;
        end
      endcase
    end

    // sticky faults: a new fault wins over a write-one clear
    if (do_write && wr_addr == `DSCG_STATUS_OFF) begin
      next_q.status = q.status & ~wbits;
    end
    next_q.status = (next_q.status | fault_set) & `DSCG_GATE_WMASK;
    next_q.irq = (next_q.status & next_q.mask) != 32'h0000_0000;

    // read channel, one outstanding
    if (s_axi_arvalid && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = `DSCG_RESP_OKAY;
      case (araddr)
        `DSCG_RUN_CFG_OFF: next_q.rdata = q.run_clock_config;
        `DSCG_RUN_GATE_OFF: next_q.rdata = q.run_clock_gate_0;
        `DSCG_SLEEP_GATE_OFF: next_q.rdata = q.sleep_clock_gate_0;
        `DSCG_DEEP_GATE_OFF: next_q.rdata = q.deep_sleep_clock_gate_0;
        `DSCG_STATUS_OFF: next_q.rdata = q.status;
        `DSCG_MASK_OFF: next_q.rdata = q.mask;
        default: begin
          next_q.rdata = 32'h0000_0000;
          next_q.rresp = `DSCG_RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end

    // readies are registered; they drop while an answer is pending
    next_q.awready = !next_q.aw_got && !next_q.bvalid;
    next_q.wready = !next_q.w_got && !next_q.bvalid;
    next_q.arready = !next_q.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RST;
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rdata = q.rdata;
  assign periph_fault = q.periph_fault;
  assign periph_done = q.periph_done;
  assign unit_clk_en = gate_en;
  assign power_mode = q.mode;
  assign irq = q.irq;

endmodule // dscg_top

`default_nettype wire

// ==== testbench/dscg_top_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module dscg_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic periph_req,
  input wire dscg_pkg::dscg_units_t periph_sel,
  input wire logic periph_fault,
  input wire logic periph_done,
  input wire dscg_pkg::dscg_units_t unit_clk_en,
  input wire logic [1:0] power_mode,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst_en; $rose(aresetn) |-> unit_clk_en == 4'h2; endproperty
  a_rst_en: assert property (p_rst_en)
    else $error("enables wrong after reset");
  property p_ack; periph_req |=> periph_fault ^ periph_done; endproperty
  a_ack: assert property (p_ack)
    else $error("unit access not answered once");
  property p_fault;
    periph_req && |(periph_sel & ~unit_clk_en) |=> periph_fault;
  endproperty
  a_fault: assert property (p_fault)
    else $error("gated unit access without fault");
  property p_blat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_blat: assert property (p_blat)
    else $error("write response late");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rlat: assert property (p_rlat)
    else $error("read data late");
  property p_rzero;
    s_axi_rvalid |-> (s_axi_rdata & 32'hF7EE_FFB7) == 32'h0000_0000;
  endproperty
  a_rzero: assert property (p_rzero)
    else $error("reserved bits read nonzero");
  property p_irq; $changed(irq) |-> periph_fault || $rose(s_axi_bvalid);
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq moved without cause");
  // enables move only two edges after a register commit or mode step
  property p_quiet;
    !($rose(s_axi_bvalid) || $changed(power_mode))
      |-> ##2 $stable(unit_clk_en);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("enable changed without cause");
endmodule // dscg_top_sva
bind dscg_top dscg_top_sva dscg_top_sva_i (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .periph_req(periph_req),
  .periph_sel(periph_sel), .periph_fault(periph_fault),
  .periph_done(periph_done), .unit_clk_en(unit_clk_en),
  .power_mode(power_mode), .irq(irq)
);
`default_nettype wire

// ==== testbench/dscg_top_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module dscg_top_tb;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, sleep_req = 1'b0, deep_sleep_req = 1'b0;
  logic periph_req = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  dscg_pkg::dscg_units_t periph_sel = 4'h0, unit_clk_en;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, periph_fault, periph_done, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, power_mode;
  logic [33:0] exp_q[$];
  int err_total = 0, comparisons = 0;

  dscg_top dscg_top_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .sleep_req(sleep_req),
    .deep_sleep_req(deep_sleep_req), .periph_req(periph_req),
    .periph_sel(periph_sel), .periph_fault(periph_fault),
    .periph_done(periph_done), .unit_clk_en(unit_clk_en),
    .power_mode(power_mode), .irq(irq)
  );

  always #2.5 aclk = ~aclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] u(logic [31:0] v);
    return {v[20], v[16], v[6], v[3]};
  endfunction

  task automatic chk(string n, logic [33:0] s, logic [33:0] e);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // aw and w offered together, each released once taken
  task automatic wr(logic [11:0] a, logic [31:0] v, logic [3:0] s,
                    logic [1:0] rs);
    bit aw_p, w_p;
    exp_q.push_back({rs, 32'h0});
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_p = 1;
    w_p = 1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_axi_awready) begin
        aw_p = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready) begin
        w_p = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] e, logic [1:0] rs);
    exp_q.push_back({rs, e});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic pa(logic [3:0] s, logic f);
    exp_q.push_back({32'h0, f, !f});
    @(posedge aclk);
    periph_req <= 1'b1;
    periph_sel <= s;
    @(posedge aclk);
    periph_req <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic md(logic s, logic dp, logic [1:0] pm, logic [3:0] e);
    @(posedge aclk);
    sleep_req <= s;
    deep_sleep_req <= dp;
    repeat (6) @(posedge aclk);
    chk("mode", 34'(power_mode), 34'(pm));
    chk("clk_en", 34'(unit_clk_en), 34'(e));
  endtask

  // ----------------------------------------------------------------
  // result monitor
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (aresetn && s_axi_rvalid && s_axi_rready) begin
      chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    end
    if (aresetn && s_axi_bvalid && s_axi_bready) begin
      chk("bresp", {s_axi_bresp, 32'h0}, exp_q.pop_front());
    end
    if (aresetn && (periph_fault || periph_done)) begin
      chk("unit", {32'h0, periph_fault, periph_done}, exp_q.pop_front());
    end
  end

  initial begin
    repeat (5000) @(posedge aclk);
    err_total++;
    test_done;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    r = $urandom(32'hD47547F4);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h060, 32'h0, 2'h0);
    for (int i = 0; i < 3; i++) rd(12'h100 + 12'(i * 16), 32'h40, 2'h0);
    rd(12'h130, 32'h0, 2'h0);
    rd(12'h200, 32'h0, 2'h2);
    chk("clk_en", 34'(unit_clk_en), 34'h2);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      r = $urandom;
      wr(12'h100 + 12'(i * 16), 32'hFFFF_FFFF, 4'hF, 2'h0);
      rd(12'h100 + 12'(i * 16), 32'h0011_0048, 2'h0);
      wr(12'h100 + 12'(i * 16), r, 4'h1, 2'h0);
      rd(12'h100 + 12'(i * 16), 32'h0011_0000 | (r & 32'h48), 2'h0);
    end
    wr(12'h060, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rd(12'h060, 32'h0800_0000, 2'h0);
    wr(12'h060, 32'h0, 4'hF, 2'h0);
    wr(12'h200, 32'hFFFF_FFFF, 4'hF, 2'h2);
    $display("test access done");
    wr(12'h100, 32'h0000_0008, 4'hF, 2'h0);
    wr(12'h110, 32'h0001_0000, 4'hF, 2'h0);
    d = $urandom & 32'h0011_0048;
    wr(12'h120, d, 4'hF, 2'h0);
    repeat (3) @(posedge aclk);
    chk("clk_en", 34'(unit_clk_en), 34'h1);
    for (int i = 0; i < 4; i++) pa(4'(1 << i), i != 0);
    rd(12'h130, 32'h0011_0040, 2'h0);
    chk("irq", 34'(irq), 34'h0);
    wr(12'h134, 32'h0000_0040, 4'hF, 2'h0);
    chk("irq", 34'(irq), 34'h1);
    wr(12'h130, 32'h0000_0040, 4'hF, 2'h0);
    chk("irq", 34'(irq), 34'h0);
    rd(12'h130, 32'h0011_0000, 2'h0);
    $display("test fault done");
    md(1'b1, 1'b0, 2'h1, 4'h1);
    md(1'b1, 1'b1, 2'h3, 4'h1);
    md(1'b0, 1'b0, 2'h0, 4'h1);
    wr(12'h060, 32'h0800_0000, 4'hF, 2'h0);
    md(1'b1, 1'b0, 2'h1, 4'h4);
    md(1'b1, 1'b1, 2'h3, u(d));
    pa(4'hF, u(d) != 4'hF);
    md(1'b0, 1'b0, 2'h0, 4'h1);
    $display("test modes done");
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h120, 32'h40, 2'h0);
    chk("clk_en", 34'(unit_clk_en), 34'h2);
    $display("test rereset done");
    test_done;
  end
endmodule // dscg_top_tb
`default_nettype wire
